// ---- design/gpc_map.vh ----
`ifndef GPC_MAP_VH
`define GPC_MAP_VH
// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define GPC_OFS_DATA_LAST 12'h3FC
`define GPC_OFS_DIR       12'h400
`define GPC_OFS_IS        12'h404
`define GPC_OFS_IBE       12'h408
`define GPC_OFS_IEV       12'h40C
`define GPC_OFS_IM        12'h410
`define GPC_OFS_RIS       12'h414
`define GPC_OFS_MIS       12'h418
`define GPC_OFS_ICR       12'h41C
`define GPC_OFS_AFSEL     12'h420
`define GPC_OFS_DR2       12'h500
`define GPC_OFS_DR4       12'h504
`define GPC_OFS_DR8       12'h508
`define GPC_OFS_ODR       12'h50C
`define GPC_OFS_PUR       12'h510
`define GPC_OFS_PDR       12'h514
`define GPC_OFS_SLR       12'h518
`define GPC_OFS_DEN       12'h51C
`define GPC_OFS_LOCK      12'h520
`define GPC_OFS_CR        12'h524
`define GPC_OFS_ID_FIRST  12'hFD0
// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define GPC_MASK_LSB      2
`define GPC_MASK_MSB      9
`define GPC_RST_ZERO      8'h00
`define GPC_RST_DR2       8'hFF
`define GPC_RST_LOCKED    1'b1
`define GPC_UNLOCK_KEY    32'h1ACCE551
`endif

// ---- design/gpc_pin_irq.v ----
`timescale 1ns/1ps
// One pin's synchroniser, event detector and sticky edge status
module gpc_pin_irq
(
   input  wire pclk,
   input  wire presetn,
   input  wire pin_in,
   input  wire sense,
   input  wire both,
   input  wire pol,
   input  wire clr,
   output wire level_out,
   output wire raw_out
);
   reg sync1_r;
   reg sync2_r;
   reg prev_r;
   reg edge_r;
   reg [2:0] warm_r;
   wire edge_hit;
   wire level_hit;

   // Two stages before any logic looks at the pin
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sync1_r <= 1'b0;
         sync2_r <= 1'b0;
         prev_r  <= 1'b0;
         warm_r  <= 3'b000;
      end
      else
      begin
         sync1_r <= pin_in;
         sync2_r <= sync1_r;
         prev_r  <= sync2_r;
         warm_r  <= {warm_r[1:0], 1'b1};
      end
   end

   // Edges count only once the chain holds real pin samples, so a pin idling high
   // does not look like a rising edge just after reset
   assign edge_hit  = warm_r[2] & (both ? (sync2_r ^ prev_r)
                                        : (pol ? (sync2_r & ~prev_r) : (~sync2_r & prev_r)));
   assign level_hit = pol ? sync2_r : ~sync2_r;

   // Edge latch: set beats clear so no event is lost
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         edge_r <= 1'b0;
      else if (edge_hit)
         edge_r <= 1'b1;
      else if (clr)
         edge_r <= 1'b0;
   end

   assign level_out = sync2_r;
   assign raw_out   = sense ? level_hit : edge_r;
endmodule

// ---- design/gpc_port.v ----
// Local design decisions: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "gpc_map.vh"
module gpc_port
#(
   parameter [7:0]  PROT_PINS = 8'h00,   // Debug-port pins of this port instance
   parameter [31:0] ID_VAL0   = 32'h0000_0000, // Arbitrary identification values
   parameter [31:0] ID_VAL1   = 32'h0000_0001,
   parameter [31:0] ID_VAL2   = 32'h0000_0002,
   parameter [31:0] ID_VAL3   = 32'h0000_0003
)
(
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output wire        pready,
   output wire        pslverr,
   input  wire [7:0]  pin_in,
   output reg  [7:0]  pin_out,
   output reg  [7:0]  pin_oe_n,
   input  wire [7:0]  alt_out,
   input  wire [7:0]  alt_oe,
   output reg  [7:0]  alt_in,
   output reg  [7:0]  pad_dr2,
   output reg  [7:0]  pad_dr4,
   output reg  [7:0]  pad_dr8,
   output reg  [7:0]  pad_odr,
   output reg  [7:0]  pad_pur,
   output reg  [7:0]  pad_pdr,
   output reg  [7:0]  pad_slr,
   output reg  [7:0]  pad_den,
   output reg  [7:0]  afsel_out,
   output reg         irq
);
   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   reg  [7:0]  data_r;
   reg  [7:0]  dir_r;
   reg  [7:0]  is_r;
   reg  [7:0]  ibe_r;
   reg  [7:0]  iev_r;
   reg  [7:0]  im_r;
   reg  [7:0]  afsel_r;
   reg  [7:0]  cr_r;
   reg         locked_r;
   reg  [31:0] rd_word;
   wire [7:0]  pin_lvl;
   wire [7:0]  raw;
   wire [7:0]  icr_hit;
   wire [7:0]  amask;
   wire [7:0]  din;
   wire [7:0]  data_view;
   wire [7:0]  af_allow;
   wire        wr_en;
   wire        is_data;
   wire [3:0]  id_idx;

   // ----------------------------------------------------------------
   // APB slave: zero wait states, never errors
   // ----------------------------------------------------------------
   assign pready  = 1'b1;
   assign pslverr = 1'b0;
   assign wr_en   = psel & penable & pwrite;
   assign din     = pwdata[7:0];
   assign is_data = (paddr <= `GPC_OFS_DATA_LAST);
   assign amask   = paddr[`GPC_MASK_MSB:`GPC_MASK_LSB];
   assign icr_hit = (wr_en && paddr == `GPC_OFS_ICR) ? din : 8'h00;

   // ----------------------------------------------------------------
   // Per-pin detection
   // ----------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < 8; g = g + 1)
      begin : pin_g
         gpc_pin_irq u_pin
         (
            .pclk      (pclk),
            .presetn   (presetn),
            .pin_in    (pin_in[g]),
            .sense     (is_r[g]),
            .both      (ibe_r[g]),
            .pol       (iev_r[g]),
            .clr       (icr_hit[g]),
            .level_out (pin_lvl[g]),
            .raw_out   (raw[g])
         );
      end
   endgenerate

   // Outputs read the written value, inputs the synchronised pin
   assign data_view = (data_r & dir_r) | (pin_lvl & ~dir_r);
   // Protected select bits move only when unlocked and committed
   assign af_allow  = ~PROT_PINS | ({8{~locked_r}} & cr_r);

   // ----------------------------------------------------------------
   // Register writes
   // ----------------------------------------------------------------
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         data_r   <= `GPC_RST_ZERO;
         dir_r    <= `GPC_RST_ZERO;
         is_r     <= `GPC_RST_ZERO;
         ibe_r    <= `GPC_RST_ZERO;
         iev_r    <= `GPC_RST_ZERO;
         im_r     <= `GPC_RST_ZERO;
         afsel_r  <= PROT_PINS;
         pad_pur  <= PROT_PINS;
         pad_den  <= PROT_PINS;
         pad_pdr  <= `GPC_RST_ZERO;
         pad_dr2  <= `GPC_RST_DR2;
         pad_dr4  <= `GPC_RST_ZERO;
         pad_dr8  <= `GPC_RST_ZERO;
         pad_odr  <= `GPC_RST_ZERO;
         pad_slr  <= `GPC_RST_ZERO;
         cr_r     <= ~PROT_PINS;
         locked_r <= `GPC_RST_LOCKED;
      end
      else if (wr_en)
      begin
         if (is_data)
            data_r <= (data_r & ~amask) | (din & amask);
         else
         begin
            case (paddr)
               `GPC_OFS_DIR:   dir_r   <= din;
               `GPC_OFS_IS:    is_r    <= din;
               `GPC_OFS_IBE:   ibe_r   <= din;
               `GPC_OFS_IEV:   iev_r   <= din;
               `GPC_OFS_IM:    im_r    <= din;
               `GPC_OFS_AFSEL: afsel_r <= (afsel_r & ~af_allow) | (din & af_allow);
               `GPC_OFS_DR2:   pad_dr2 <= din;
               `GPC_OFS_DR4:   pad_dr4 <= din;
               `GPC_OFS_DR8:   pad_dr8 <= din;
               `GPC_OFS_ODR:   pad_odr <= din;
               `GPC_OFS_PUR:   pad_pur <= din;
               `GPC_OFS_PDR:   pad_pdr <= din;
               `GPC_OFS_SLR:   pad_slr <= din;
               `GPC_OFS_DEN:   pad_den <= din;
               `GPC_OFS_LOCK:  locked_r <= (pwdata != `GPC_UNLOCK_KEY);
               `GPC_OFS_CR:
               begin
                  // Only protected bits are writable, and only when unlocked
                  if (!locked_r)
                     cr_r <= (cr_r & ~PROT_PINS) | (din & PROT_PINS);
               end
               default: ;
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // Read mux
   // ----------------------------------------------------------------
   assign id_idx = paddr[5:2];
   always @*
   begin
      rd_word = 32'h0000_0000;
      if (is_data)
         rd_word = {24'h00_0000, data_view & amask};
      else if (paddr >= `GPC_OFS_ID_FIRST)
      begin
         // Identification block, read-only
         case (id_idx)
            4'hC: rd_word = ID_VAL0;
            4'hD: rd_word = ID_VAL1;
            4'hE: rd_word = ID_VAL2;
            4'hF: rd_word = ID_VAL3;
            default: rd_word = 32'h0000_0000;
         endcase
      end
      else
      begin
         case (paddr)
            `GPC_OFS_DIR:   rd_word[7:0] = dir_r;
            `GPC_OFS_IS:    rd_word[7:0] = is_r;
            `GPC_OFS_IBE:   rd_word[7:0] = ibe_r;
            `GPC_OFS_IEV:   rd_word[7:0] = iev_r;
            `GPC_OFS_IM:    rd_word[7:0] = im_r;
            `GPC_OFS_RIS:   rd_word[7:0] = raw;
            `GPC_OFS_MIS:   rd_word[7:0] = raw & im_r;
            `GPC_OFS_AFSEL: rd_word[7:0] = afsel_r;
            `GPC_OFS_DR2:   rd_word[7:0] = pad_dr2;
            `GPC_OFS_DR4:   rd_word[7:0] = pad_dr4;
            `GPC_OFS_DR8:   rd_word[7:0] = pad_dr8;
            `GPC_OFS_ODR:   rd_word[7:0] = pad_odr;
            `GPC_OFS_PUR:   rd_word[7:0] = pad_pur;
            `GPC_OFS_PDR:   rd_word[7:0] = pad_pdr;
            `GPC_OFS_SLR:   rd_word[7:0] = pad_slr;
            `GPC_OFS_DEN:   rd_word[7:0] = pad_den;
            `GPC_OFS_LOCK:  rd_word[0]   = locked_r;
            `GPC_OFS_CR:    rd_word[7:0] = cr_r;
            default:        rd_word = 32'h0000_0000;
         endcase
      end
   end

   // prdata is registered in the setup phase so it is valid in the access phase
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata <= 32'h0000_0000;
      else if (psel && !penable && !pwrite)
         prdata <= rd_word;
   end

   // ----------------------------------------------------------------
   // Pin and interrupt outputs, all registered
   // ----------------------------------------------------------------
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pin_out   <= 8'h00;
         pin_oe_n  <= 8'hFF;
         alt_in    <= 8'h00;
         afsel_out <= PROT_PINS;
         irq       <= 1'b0;
      end
      else
      begin
         // Peripheral or software data; open-drain releases the pin for a one
         pin_out   <= afsel_r & alt_out | ~afsel_r & data_r;
         pin_oe_n  <= ~(pad_den & ((afsel_r & alt_oe) | (~afsel_r & dir_r))
                        & ~(pad_odr & (afsel_r & alt_out | ~afsel_r & data_r)));
         alt_in    <= pin_lvl & afsel_r & pad_den;
         afsel_out <= afsel_r;
         irq       <= |(raw & im_r);
      end
   end
endmodule

// ---- tb/gpc_pin_model.sv ----
`timescale 1ns/1ps
// ----------------------------------------
// Pad and outside-world model
// ----------------------------------------
module gpc_pin_model
(
   input  wire       pclk,
   input  wire [7:0] pin_out,
   input  wire [7:0] pin_oe_n,
   input  wire [7:0] pad_pur,
   input  wire [7:0] pad_pdr,
   input  wire [7:0] ext_lvl,
   input  wire [7:0] ext_en,
   output logic [7:0] pin_in
);
   logic [7:0] flt_r = 8'h00;
   // A floating pad wanders so an unknown never settles to a lucky value
   always @(posedge pclk)
      flt_r <= ~flt_r;
   // Device drive wins, then the outside source, then the pulls
   always @*
   begin
      for (int i = 0; i < 8; i++)
      begin
         if (!pin_oe_n[i])
            pin_in[i] = pin_out[i];
         else if (ext_en[i])
            pin_in[i] = ext_lvl[i];
         else if (pad_pur[i])
            pin_in[i] = 1'b1;
         else if (pad_pdr[i])
            pin_in[i] = 1'b0;
         else
            pin_in[i] = flt_r[i];
      end
   end
endmodule

// ---- tb/gpc_port_monitor.sv ----
`timescale 1ns/1ps
// ----------------------------------------
// Port checker
// ----------------------------------------
module gpc_port_monitor
#(
   parameter [7:0] PROT_PINS = 8'h00
)
(
   input wire        pclk,
   input wire        presetn,
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire        pready,
   input wire        pslverr,
   input wire [7:0]  pin_out,
   input wire [7:0]  pin_oe_n,
   input wire [7:0]  pad_dr2,
   input wire [7:0]  pad_odr,
   input wire [7:0]  pad_pur,
   input wire [7:0]  pad_pdr,
   input wire [7:0]  pad_den,
   input wire [7:0]  afsel_out,
   input wire        irq
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Read setup and completed write strobes
   wire rd_su = psel && !penable && !pwrite;
   wire wr_do = psel && penable && pwrite;
   property p_rst_oe; $rose(presetn) |-> pin_oe_n == 8'hFF; endproperty
   a_rst_oe: assert property (p_rst_oe) else $error("pins driven after reset");
   property p_rst_pad;
      $rose(presetn) |-> afsel_out == PROT_PINS && pad_pur == PROT_PINS && pad_den == PROT_PINS
         && pad_pdr == 8'h00 && pad_dr2 == 8'hFF;
   endproperty
   a_rst_pad: assert property (p_rst_pad) else $error("pad reset values wrong");
   property p_rd_mask;
      rd_su && paddr[11:10] == 2'b00 |=> prdata[31:8] == 24'h0 && (prdata[7:0] & ~$past(paddr[9:2])) == 8'h00;
   endproperty
   a_rd_mask: assert property (p_rd_mask) else $error("masked data bit read non-zero");
   property p_im_zero; wr_do && paddr == 12'h410 && pwdata[7:0] == 8'h00 |-> ##2 !irq[*3]; endproperty
   a_im_zero: assert property (p_im_zero) else $error("irq with all pins masked");
   property p_oe_den; (~pin_oe_n & ~pad_den & ~$past(pad_den)) == 8'h00; endproperty
   a_oe_den: assert property (p_oe_den) else $error("pin driven without digital enable");
   property p_od_low; (~pin_oe_n & pad_odr & $past(pad_odr) & pin_out) == 8'h00; endproperty
   a_od_low: assert property (p_od_low) else $error("open drain drives high");
   property p_resp; psel && penable |-> pready && !pslverr; endproperty
   a_resp: assert property (p_resp) else $error("bad bus response");
   property p_id_low; rd_su && paddr >= 12'hFD0 && paddr < 12'hFF0 |=> prdata == 32'h0; endproperty
   a_id_low: assert property (p_id_low) else $error("low ident word not zero");
endmodule
bind gpc_port gpc_port_monitor #(.PROT_PINS(PROT_PINS)) i_mon (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pad_dr2(pad_dr2), .pad_odr(pad_odr),
   .pad_pur(pad_pur), .pad_pdr(pad_pdr), .pad_den(pad_den), .afsel_out(afsel_out), .irq(irq));

// ---- tb/tb_gpio_port_core.sv ----
`timescale 1ns/1ps
// ----------------------------------------
// Testbench
// ----------------------------------------
module tb_gpio_port_core;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, irq;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, q;
   logic [7:0] pin_in, pin_out, pin_oe_n, pad_odr, pad_pur, pad_pdr, afsel_out;
   logic [7:0] ext_lvl = 8'h00, ext_en = 8'h00;
   logic [7:0] alt_out = 8'h00, alt_oe = 8'h00, alt_in, pad_dr8;
   int error_cnt = 0, n_checks = 0;
   always #25 pclk = ~pclk; // Port clock runs from time zero
   // Port B flavour: pin 7 is a protected debug pin
   gpc_port #(.PROT_PINS(8'h80), .ID_VAL0(32'h0000_00A5)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .alt_out(alt_out),
      .alt_oe(alt_oe), .alt_in(alt_in), .pad_dr2(), .pad_dr4(), .pad_dr8(pad_dr8), .pad_odr(pad_odr),
      .pad_pur(pad_pur),
      .pad_pdr(pad_pdr), .pad_slr(), .pad_den(), .afsel_out(afsel_out), .irq(irq));
   gpc_pin_model i_pins (.pclk(pclk), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pad_pur(pad_pur),
      .pad_pdr(pad_pdr), .ext_lvl(ext_lvl), .ext_en(ext_en), .pin_in(pin_in));
   task give_verdict;
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // One APB transfer; an idle edge always separates two transfers
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 20)
      begin
         n++;
         @(posedge pclk);
      end
      q = prdata;
      psel <= 1'b0; penable <= 1'b0;
      if (n == 20)
      begin
         error_cnt++;
         give_verdict();
      end
   endtask
   task wr(input logic [11:0] a, input logic [31:0] d); apb(1'b1, a, d); endtask
   task rdc(input logic [11:0] a, input logic [31:0] e); apb(1'b0, a, e); chk(q, e); endtask
   // Settle a few edges, then look just after the last one
   task cyc(input int n); repeat (n) @(posedge pclk); #1; endtask
   // Bounded wait for the interrupt line to reach a level
   task wirq(input logic v);
      int n;
      n = 0;
      cyc(1);
      while (irq !== v && n < 20)
      begin
         n++;
         cyc(1);
      end
      chk(irq, v);
      if (n == 20)
         give_verdict();
   endtask
   task t_reset;
      rdc(12'h400, 32'h0);
      rdc(12'h500, 32'hFF);
      rdc(12'h420, 32'h80);
      rdc(12'h510, 32'h80);
      rdc(12'h51C, 32'h80);
      rdc(12'h514, 32'h0);
      rdc(12'h520, 32'h1);
      rdc(12'hFF0, 32'hA5);
      rdc(12'hFD0, 32'h0);
      rdc(12'h600, 32'h0);
      $display("t_reset done");
   endtask
   task t_data;
      wr(12'h51C, 32'hFF);
      wr(12'h400, 32'h70);
      wr(12'h3FC, 32'h00);
      wr(12'h098, 32'hEB);
      ext_lvl <= 8'h05;
      ext_en <= 8'hFF;
      cyc(5);
      chk(pin_out[6:4], 3'h2);
      chk(pin_oe_n, 8'h8F);
      rdc(12'h1FC, 32'h25);
      rdc(12'h0C4, 32'h21);
      // Open drain on pin 5, which holds a one, so the pad must be released
      wr(12'h50C, 32'h20);
      wr(12'h508, 32'h0F);
      cyc(3);
      chk({pad_odr, pin_oe_n}, 16'h20AF);
      chk(pad_dr8, 8'h0F);
      $display("t_data done");
   endtask
   // Masks first, then sense settings, clears and finally the mask again
   task setup_irq(input logic [7:0] is, input logic [7:0] ibe, input logic [7:0] iev);
      wr(12'h410, 32'h00);
      wr(12'h404, is);
      wr(12'h408, ibe);
      wr(12'h40C, iev);
      wr(12'h41C, 32'hFF);
      wr(12'h410, 32'h02);
   endtask
   task t_irq;
      setup_irq(8'h00, 8'h00, 8'h02);
      ext_lvl <= 8'h07;
      wirq(1'b1);
      rdc(12'h414, 32'h02);
      rdc(12'h418, 32'h02);
      ext_lvl <= 8'h05;
      wr(12'h41C, 32'h00);
      cyc(5);
      chk(irq, 1'b1);
      wr(12'h41C, 32'h02);
      wirq(1'b0);
      setup_irq(8'h00, 8'h02, 8'h00);
      ext_lvl <= 8'h07;
      wirq(1'b1);
      wr(12'h41C, 32'h02);
      wirq(1'b0);
      ext_lvl <= 8'h05;
      wirq(1'b1);
      setup_irq(8'h02, 8'h00, 8'h00);
      wirq(1'b1);
      wr(12'h41C, 32'h02);
      cyc(5);
      chk(irq, 1'b1);
      ext_lvl <= 8'h07;
      wirq(1'b0);
      rdc(12'h414, 32'h00);
      $display("t_irq done");
   endtask
   task t_lock;
      wr(12'h420, 32'h00);
      rdc(12'h420, 32'h80);
      wr(12'h420, 32'h01);
      rdc(12'h420, 32'h81);
      alt_out <= 8'h01;
      alt_oe <= 8'h01;
      cyc(5);
      chk({pin_out[0], pin_oe_n[0], alt_in[0]}, 3'b101);
      wr(12'h520, 32'h1ACCE551);
      rdc(12'h520, 32'h0);
      // Unlocked but not committed: the protected bit must hold
      wr(12'h420, 32'h00);
      rdc(12'h420, 32'h80);
      wr(12'h524, 32'hFF);
      wr(12'h420, 32'h00);
      rdc(12'h420, 32'h00);
      chk(afsel_out, 8'h00);
      $display("t_lock done");
   endtask
   initial
   begin
      repeat (5) @(posedge pclk); // First access comes only after five clocks
      presetn <= 1'b1;
      t_reset();
      t_data();
      t_irq();
      t_lock();
      give_verdict();
   end
endmodule
